// [include/rer_defs.vh]
`ifndef RER_DEFS_VH
`define RER_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte addresses on the APB side.
// ----------------------------------------------------------------------------
`define RER_ADDR_CTRL 8'h00
`define RER_ADDR_RETRY 8'h04
`define RER_ADDR_TIME 8'h08
`define RER_ADDR_STATUS 8'h0C
`define RER_ADDR_INFO 8'h10

// ----------------------------------------------------------------------------
// Control register field positions and reset value.
// ----------------------------------------------------------------------------
`define RER_CTRL_DISCORR 0
`define RER_CTRL_TERM 1
`define RER_CTRL_POST 2
`define RER_CTRL_RDCONT 4
`define RER_CTRL_XFAIL 5
`define RER_CTRL_ADJ 8
`define RER_CTRL_WCE 9
`define RER_CTRL_RESET 10'h000

// ----------------------------------------------------------------------------
// Retry register: read count in [7:0], write count in [15:8].
// ----------------------------------------------------------------------------
`define RER_RD_LO 0
`define RER_RD_HI 7
`define RER_WR_LO 8
`define RER_WR_HI 15
`define RER_RETRY_RESET 16'h0101
`define RER_TIME_RESET 16'h0000

// ----------------------------------------------------------------------------
// Status register field positions.
// ----------------------------------------------------------------------------
`define RER_ST_SENSE_LO 0
`define RER_ST_SENSE_HI 3
`define RER_ST_CHECK 4
`define RER_ST_BUSY 5
`define RER_ST_ILLEGAL 6
`define RER_ST_RECOV 7
`define RER_ST_PASS_LO 8
`define RER_ST_PASS_HI 15

// ----------------------------------------------------------------------------
// Sense keys, pass limits and timing.
// ----------------------------------------------------------------------------
`define RER_SENSE_NONE 4'h0
`define RER_SENSE_RECOVERED 4'h1
`define RER_SENSE_MEDIUM 4'h3
`define RER_FULL_PASSES 8'h10
`define RER_TICK_MS 50
`define RER_CLK_NS 40
`define RER_NS_PER_MS 1000000
`define RER_TICK_ROUND 17'h00031
`define RER_TICK_DIV 17'h00032

`endif

// [logic/rer_policy.v]
// What this block does
// RULE1 - Terminate bit set: halt transfer at the first recovered error.
// RULE2 - Host sets post-error whenever it sets terminate.
// RULE3 - Terminate bit clear: keep transferring past recovered errors.
// RULE4 - Read retry count limits read recovery passes; zero disables read recovery.
// RULE5 - Adjustable bit clear: any non-zero read count enables all recovery steps.
// RULE6 - Adjustable bit set: read count is the maximum number of passes.
// RULE7 - Write retry count limits write recovery passes; zero disables write recovery.
// RULE8 - Time limit in 1 ms units per block; host programs 40 to 65535.
// RULE9 - Elapsed recovery time measured in 50 ms steps.
// RULE10 - Block not recovered before time limit: end with Check Condition.
// RULE11 - Write cache enabled: no time limit on writes.
// RULE12 - Time limit zero disables the per-block timer.
// RULE13 - Illegal mode combinations are still accepted without error.
// RULE14 - Mode 000: retry and correct, no Check Condition for recovered errors.
// RULE15 - No error, or recovered only without post-error: transfer full length.
// RULE16 - Unrecoverable error: stop transfer, then Check Condition with sense key.
// RULE17 - Mode 001 sends the failed block; other modes withhold it. The code sends it in modes 000 and 001 when XFAIL is set, else withholds it.
// RULE18 - Host never sets terminate without post-error; such modes are illegal.
// RULE19 - Mode 100: transfer recovered data, Recovered Error check at end.
// RULE20 - In that mode the information field holds the last recovered LBA.
// RULE21 - Post-error set makes the device report recovered errors.
// RULE22 - Failed block sent only as allowed; recoverable blocks always sent.
// RULE23 - Read-continuous overrides the other error bits, on reads only.
// RULE24 - Programmed limit rounds up to whole 50 ms ticks at timer load.
// RULE25 - Pass counter clears per block and stops at the retry limit.
`include "rer_defs.vh"

module rer_policy #(
  parameter TICK_CYCLES = `RER_TICK_MS * `RER_NS_PER_MS / `RER_CLK_NS
) (
  input wire CLK_IN,
  input wire RST_N_IN,
  input wire CE_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire PWRITE_IN,
  input wire [7:0] PADDR_IN,
  input wire [31:0] PWDATA_IN,
  output reg [31:0] PRDATA_OUT,
  output reg PREADY_OUT,
  output reg PSLVERR_OUT,
  input wire CMD_START_IN,
  input wire CMD_WRITE_IN,
  input wire [15:0] CMD_BLOCKS_IN,
  input wire BLK_DONE_IN,
  input wire BLK_ERR_IN,
  input wire [31:0] BLK_LBA_IN,
  input wire PASS_DONE_IN,
  input wire PASS_OK_IN,
  output reg PASS_REQ_OUT,
  output reg FULL_STEPS_OUT,
  output reg XFER_BLOCK_OUT,
  output reg XFER_STOP_OUT,
  output reg CMD_DONE_OUT,
  output reg CHECK_COND_OUT,
  output reg [3:0] SENSE_KEY_OUT,
  output reg [31:0] INFO_LBA_OUT,
  output reg BUSY_OUT
);

  // --------------------------------------------------------------------------
  // States of the command sequencer.
  // --------------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_XFER = 2'b01;
  localparam [1:0] ST_REQ = 2'b10;
  localparam [1:0] ST_WAIT = 2'b11;
  localparam [20:0] TICK_LAST = TICK_CYCLES[20:0] - 21'h000001;

  // Software-visible configuration.
  reg [9:0] ctrl_reg;
  reg [15:0] retry_reg;
  reg [15:0] time_reg;

  // Per-command state.
  reg [1:0] state_reg;
  reg [15:0] blocks_reg;
  reg [7:0] pass_reg;
  reg [7:0] limit_reg;
  reg is_write_reg;
  reg post_reg;
  reg term_reg;
  reg xfail_reg;
  reg rdcont_reg;
  reg timer_on_reg;
  reg [15:0] ticks_reg;
  reg [20:0] presc_reg;
  reg recov_seen_reg;
  reg [31:0] last_lba_reg;

  // --------------------------------------------------------------------------
  // Decoded mode terms.
  // --------------------------------------------------------------------------
  wire cfg_post = ctrl_reg[`RER_CTRL_POST];
  wire cfg_term = ctrl_reg[`RER_CTRL_TERM];
  wire cfg_adj = ctrl_reg[`RER_CTRL_ADJ];
  wire cfg_wce = ctrl_reg[`RER_CTRL_WCE];
  wire [7:0] rd_count = retry_reg[`RER_RD_HI:`RER_RD_LO];
  wire [7:0] wr_count = retry_reg[`RER_WR_HI:`RER_WR_LO];

  // The illegal combination is only flagged; the sequencer runs it anyway.
  wire illegal_mode = cfg_term & ~cfg_post; // RULE13 RULE18

  // A fixed default pass budget stands for "every step" on reads.
  wire [7:0] rd_limit = (rd_count == 8'h00) ? 8'h00 :
                        (cfg_adj ? rd_count : `RER_FULL_PASSES); // RULE4 RULE5 RULE6
  wire [7:0] cmd_limit = CMD_WRITE_IN ? wr_count : rd_limit; // RULE7

  // Round the millisecond limit up to whole ticks; the 17-bit sum cannot wrap.
  wire [16:0] lim_round = {1'b0, time_reg} + `RER_TICK_ROUND;
  wire [16:0] lim_ticks = lim_round / `RER_TICK_DIV; // RULE24
  wire tick = (presc_reg == TICK_LAST);
  wire expired = timer_on_reg & (ticks_reg == 16'h0000); // RULE10

  // --------------------------------------------------------------------------
  // APB slave: one wait-free access phase, writes land at the access edge.
  // --------------------------------------------------------------------------
  wire apb_setup = PSEL_IN & ~PENABLE_IN;
  wire apb_access = PSEL_IN & PENABLE_IN & PREADY_OUT;
  // Status bits as software sees them.
  wire [15:0] status_word = {pass_reg, recov_seen_reg, illegal_mode, BUSY_OUT,
                             CHECK_COND_OUT, SENSE_KEY_OUT};
  wire addr_ok = (PADDR_IN == `RER_ADDR_CTRL) | (PADDR_IN == `RER_ADDR_RETRY) |
                 (PADDR_IN == `RER_ADDR_TIME) | (PADDR_IN == `RER_ADDR_STATUS) |
                 (PADDR_IN == `RER_ADDR_INFO);

  reg [31:0] rd_mux;

  // Read data selection; unmapped addresses read zero.
  always @* begin
    if (PADDR_IN == `RER_ADDR_CTRL) begin
      rd_mux = {22'h000000, ctrl_reg};
    end else if (PADDR_IN == `RER_ADDR_RETRY) begin
      rd_mux = {16'h0000, retry_reg};
    end else if (PADDR_IN == `RER_ADDR_TIME) begin
      rd_mux = {16'h0000, time_reg};
    end else if (PADDR_IN == `RER_ADDR_STATUS) begin
      rd_mux = {16'h0000, status_word};
    end else if (PADDR_IN == `RER_ADDR_INFO) begin
      rd_mux = INFO_LBA_OUT;
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // Bus handshake and configuration writes. Mode writes are never refused.
  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= 32'h00000000;
      ctrl_reg <= `RER_CTRL_RESET;
      retry_reg <= `RER_RETRY_RESET;
      time_reg <= `RER_TIME_RESET;
    end else if (CE_IN) begin
      if (apb_setup) begin
        PREADY_OUT <= 1'b1;
        PSLVERR_OUT <= ~addr_ok;
        PRDATA_OUT <= PWRITE_IN ? 32'h00000000 : rd_mux;
      end else begin
        PREADY_OUT <= 1'b0;
        PSLVERR_OUT <= 1'b0;
      end
      // Writes land only at the access edge.
      if (apb_access && PWRITE_IN) begin
        if (PADDR_IN == `RER_ADDR_CTRL) begin
          ctrl_reg <= PWDATA_IN[9:0]; // RULE13
        end else if (PADDR_IN == `RER_ADDR_RETRY) begin
          retry_reg <= PWDATA_IN[15:0];
        end else if (PADDR_IN == `RER_ADDR_TIME) begin
          time_reg <= PWDATA_IN[15:0]; // RULE8
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Per-block recovery timer. The prescaler restarts at each load, so the
  // first tick arrives a full 50 ms after recovery begins.
  // --------------------------------------------------------------------------
  // Reloaded on every errored block.
  wire timer_load = (state_reg == ST_XFER) & BLK_DONE_IN & BLK_ERR_IN;

  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      presc_reg <= 21'h000000;
      ticks_reg <= 16'h0000;
    end else if (CE_IN) begin
      if (timer_load) begin
        presc_reg <= 21'h000000;
        ticks_reg <= lim_ticks[15:0]; // RULE24
      end else if (timer_on_reg && ticks_reg != 16'h0000) begin
        if (tick) begin
          presc_reg <= 21'h000000;
          ticks_reg <= ticks_reg - 16'h0001; // RULE9
        end else begin
          presc_reg <= presc_reg + 21'h000001;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Command sequencer: blocks, recovery passes, stop and status.
  // --------------------------------------------------------------------------
  // Helper terms for the sequencer.
  wire last_block = (blocks_reg == 16'h0001);
  wire send_failed = xfail_reg & ~post_reg & ~term_reg; // RULE17 RULE22
  wire pass_exhausted = ((pass_reg + 8'h01) >= limit_reg);

  always @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_reg <= ST_IDLE;
      blocks_reg <= 16'h0000;
      pass_reg <= 8'h00;
      limit_reg <= 8'h00;
      is_write_reg <= 1'b0;
      post_reg <= 1'b0;
      term_reg <= 1'b0;
      xfail_reg <= 1'b0;
      rdcont_reg <= 1'b0;
      timer_on_reg <= 1'b0;
      recov_seen_reg <= 1'b0;
      last_lba_reg <= 32'h00000000;
      PASS_REQ_OUT <= 1'b0;
      FULL_STEPS_OUT <= 1'b0;
      XFER_BLOCK_OUT <= 1'b0;
      XFER_STOP_OUT <= 1'b0;
      CMD_DONE_OUT <= 1'b0;
      CHECK_COND_OUT <= 1'b0;
      SENSE_KEY_OUT <= `RER_SENSE_NONE;
      INFO_LBA_OUT <= 32'h00000000;
      BUSY_OUT <= 1'b0;
    end else if (CE_IN) begin
      PASS_REQ_OUT <= 1'b0;
      XFER_BLOCK_OUT <= 1'b0;
      CMD_DONE_OUT <= 1'b0;
      case (state_reg)
        // Take a start only while idle.
        ST_IDLE: begin
          if (CMD_START_IN) begin
            // Latch the mode and pass limit; WCE and the time limit are still read live at each errored block.
            is_write_reg <= CMD_WRITE_IN;
            post_reg <= cfg_post;
            term_reg <= cfg_term;
            xfail_reg <= ctrl_reg[`RER_CTRL_XFAIL];
            rdcont_reg <= ctrl_reg[`RER_CTRL_RDCONT] & ~CMD_WRITE_IN; // RULE23
            limit_reg <= cmd_limit;
            FULL_STEPS_OUT <= ~CMD_WRITE_IN & ~cfg_adj & (rd_count != 8'h00); // RULE5
            blocks_reg <= CMD_BLOCKS_IN;
            recov_seen_reg <= 1'b0;
            pass_reg <= 8'h00;
            XFER_STOP_OUT <= 1'b0;
            CHECK_COND_OUT <= 1'b0;
            SENSE_KEY_OUT <= `RER_SENSE_NONE;
            if (CMD_BLOCKS_IN == 16'h0000) begin
              CMD_DONE_OUT <= 1'b1;
            end else begin
              BUSY_OUT <= 1'b1;
              state_reg <= ST_XFER;
            end
          end
        end

        // Pass blocks on or enter recovery.
        ST_XFER: begin
          if (BLK_DONE_IN) begin
            if (!BLK_ERR_IN || rdcont_reg) begin
              // Clean block, or read-continuous passing data on unchecked.
              XFER_BLOCK_OUT <= 1'b1; // RULE15 RULE23
              blocks_reg <= blocks_reg - 16'h0001;
              if (last_block) begin
                CMD_DONE_OUT <= 1'b1;
                BUSY_OUT <= 1'b0;
                state_reg <= ST_IDLE;
                if (post_reg && recov_seen_reg && !rdcont_reg) begin
                  CHECK_COND_OUT <= 1'b1; // RULE19 RULE21
                  SENSE_KEY_OUT <= `RER_SENSE_RECOVERED;
                  INFO_LBA_OUT <= last_lba_reg; // RULE20
                end
              end
            end else if (limit_reg == 8'h00) begin
              // Recovery disabled: the block fails at once.
              XFER_BLOCK_OUT <= send_failed; // RULE4 RULE7 RULE17
              XFER_STOP_OUT <= 1'b1; // RULE16
              CHECK_COND_OUT <= 1'b1;
              SENSE_KEY_OUT <= `RER_SENSE_MEDIUM;
              INFO_LBA_OUT <= BLK_LBA_IN;
              CMD_DONE_OUT <= 1'b1;
              BUSY_OUT <= 1'b0;
              state_reg <= ST_IDLE;
            end else begin
              pass_reg <= 8'h00; // RULE25
              timer_on_reg <= (time_reg != 16'h0000) & ~(is_write_reg & cfg_wce); // RULE11 RULE12
              INFO_LBA_OUT <= BLK_LBA_IN;
              state_reg <= ST_REQ;
            end
          end
        end

        // Ask the media for one pass.
        ST_REQ: begin
          PASS_REQ_OUT <= 1'b1;
          state_reg <= ST_WAIT;
        end

        // Await a pass result or expiry.
        ST_WAIT: begin
          if (expired) begin
            // Out of time for this block: same ending as a hard error.
            timer_on_reg <= 1'b0;
            XFER_BLOCK_OUT <= send_failed; // RULE17
            XFER_STOP_OUT <= 1'b1; // RULE10 RULE16
            CHECK_COND_OUT <= 1'b1;
            SENSE_KEY_OUT <= `RER_SENSE_MEDIUM;
            CMD_DONE_OUT <= 1'b1;
            BUSY_OUT <= 1'b0;
            state_reg <= ST_IDLE;
          end else if (PASS_DONE_IN) begin
            if (PASS_OK_IN) begin
              // Recovered blocks always go to the host.
              timer_on_reg <= 1'b0;
              XFER_BLOCK_OUT <= 1'b1; // RULE22
              recov_seen_reg <= 1'b1;
              last_lba_reg <= INFO_LBA_OUT;
              blocks_reg <= blocks_reg - 16'h0001;
              if (term_reg) begin
                XFER_STOP_OUT <= 1'b1; // RULE1
                CHECK_COND_OUT <= 1'b1;
                SENSE_KEY_OUT <= `RER_SENSE_RECOVERED;
                CMD_DONE_OUT <= 1'b1;
                BUSY_OUT <= 1'b0;
                state_reg <= ST_IDLE;
              end else if (last_block) begin
                CMD_DONE_OUT <= 1'b1;
                BUSY_OUT <= 1'b0;
                state_reg <= ST_IDLE;
                if (post_reg) begin
                  CHECK_COND_OUT <= 1'b1; // RULE19 RULE21
                  SENSE_KEY_OUT <= `RER_SENSE_RECOVERED;
                end // RULE14
              end else begin
                state_reg <= ST_XFER; // RULE3 RULE15
              end
            end else if (pass_exhausted) begin
              timer_on_reg <= 1'b0;
              XFER_BLOCK_OUT <= send_failed; // RULE17
              XFER_STOP_OUT <= 1'b1; // RULE16
              CHECK_COND_OUT <= 1'b1;
              SENSE_KEY_OUT <= `RER_SENSE_MEDIUM;
              CMD_DONE_OUT <= 1'b1;
              BUSY_OUT <= 1'b0;
              state_reg <= ST_IDLE;
            end else begin
              pass_reg <= pass_reg + 8'h01; // RULE25
              state_reg <= ST_REQ;
            end
          end
        end

        // Unused code falls back to idle.
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// [testbench/rer_policy_checker.sv]
// ----------------------------------------------------------------------------
// Port checker for the error recovery policy block.
// ----------------------------------------------------------------------------
module rer_policy_checker #(
  parameter TICK_CYCLES = 4
) (
  input wire CLK_IN,
  input wire RST_N_IN,
  input wire CE_IN,
  input wire PSEL_IN,
  input wire PENABLE_IN,
  input wire [7:0] PADDR_IN,
  input wire PREADY_OUT,
  input wire PSLVERR_OUT,
  input wire CMD_START_IN,
  input wire BLK_DONE_IN,
  input wire BLK_ERR_IN,
  input wire PASS_DONE_IN,
  input wire PASS_OK_IN,
  input wire PASS_REQ_OUT,
  input wire XFER_BLOCK_OUT,
  input wire XFER_STOP_OUT,
  input wire CMD_DONE_OUT,
  input wire CHECK_COND_OUT,
  input wire [3:0] SENSE_KEY_OUT,
  input wire BUSY_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  // A failed pass either ends the command or asks for the next pass.
  sequence s_setup; CE_IN && PSEL_IN && !PENABLE_IN; endsequence
  sequence s_after_fail; ##1 CMD_DONE_OUT or ##2 PASS_REQ_OUT; endsequence

  property p_ready; s_setup |=> PREADY_OUT; endproperty
  a_ready: assert property (p_ready) else $error("ready missing after setup");
  property p_ready_one; PREADY_OUT |=> !PREADY_OUT; endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready longer than one cycle");
  property p_unmapped; s_setup ##0 (PADDR_IN > 8'h10) |=> PSLVERR_OUT && PREADY_OUT; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_err_ready; PSLVERR_OUT |-> PREADY_OUT; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_clean_sent; CE_IN && BUSY_OUT && BLK_DONE_IN && !BLK_ERR_IN |=> XFER_BLOCK_OUT; endproperty
  a_clean_sent: assert property (p_clean_sent) else $error("good block not sent");
  property p_recovered_sent; CE_IN && BUSY_OUT && PASS_DONE_IN && PASS_OK_IN |=> XFER_BLOCK_OUT; endproperty
  a_recovered_sent: assert property (p_recovered_sent) else $error("recovered block not sent");
  property p_failed_pass; CE_IN && BUSY_OUT && PASS_DONE_IN && !PASS_OK_IN |-> s_after_fail; endproperty
  a_failed_pass: assert property (p_failed_pass) else $error("no outcome after failed pass");
  property p_check_at_done; $rose(CHECK_COND_OUT) |-> CMD_DONE_OUT; endproperty
  a_check_at_done: assert property (p_check_at_done) else $error("check raised outside done");
  property p_stop_checks; CMD_DONE_OUT && XFER_STOP_OUT |-> CHECK_COND_OUT && SENSE_KEY_OUT != 4'h0; endproperty
  a_stop_checks: assert property (p_stop_checks) else $error("halt without check status");
  property p_clean_done; CMD_DONE_OUT && !CHECK_COND_OUT |-> SENSE_KEY_OUT == 4'h0; endproperty
  a_clean_done: assert property (p_clean_done) else $error("sense key without check");
  property p_done_idle; CMD_DONE_OUT |=> !BUSY_OUT; endproperty
  a_done_idle: assert property (p_done_idle) else $error("busy after done");
  property p_start_busy; CE_IN && CMD_START_IN && !BUSY_OUT |=> BUSY_OUT; endproperty
  a_start_busy: assert property (p_start_busy) else $error("start not taken");
endmodule

bind rer_policy rer_policy_checker #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.*);

// [testbench/rer_media_model.sv]
// ----------------------------------------------------------------------------
// Media side model: reads blocks and runs recovery passes on request.
// ----------------------------------------------------------------------------
module rer_media_model #(
  parameter BLOCKS = 3
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic busy_in,
  input wire logic xfer_block_in,
  input wire logic pass_req_in,
  input wire logic xfer_stop_in,
  input wire logic cmd_done_in,
  input wire logic [7:0] err_mask_in,
  input wire logic [4:0] ok_pass_in,
  input wire logic [2:0] slow_in,
  output logic blk_done_out,
  output logic blk_err_out,
  output logic [31:0] blk_lba_out,
  output logic pass_done_out,
  output logic pass_ok_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx, cnt, pas;
  logic nxt, pend;

  // Idle data lines toggle every cycle so that a stale value never looks valid.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      blk_done_out <= 1'b0;
      blk_err_out <= 1'b0;
      blk_lba_out <= 32'h00000000;
      pass_done_out <= 1'b0;
      pass_ok_out <= 1'b0;
      idx = 0;
      cnt = 0;
      nxt = 1'b1;
      pend = 1'b0;
    end else begin
      blk_done_out <= 1'b0;
      pass_done_out <= 1'b0;
      blk_err_out <= ~blk_err_out;
      pass_ok_out <= ~pass_ok_out;
      blk_lba_out <= ~blk_lba_out;
      if (cnt > 0) cnt--;
      if (!busy_in) begin
        idx = 0;
        nxt = 1'b1;
        pend = 1'b0;
      end else if (cmd_done_in || xfer_stop_in) begin
        nxt = 1'b0;
        pend = 1'b0;
      end else if (xfer_block_in) begin
        nxt = 1'b1;
        cnt = slow_in;
      end else if (pass_req_in) begin
        pend = 1'b1;
        pas++;
        cnt = slow_in;
      end else if (cnt == 0 && pend) begin
        pass_done_out <= 1'b1;
        pass_ok_out <= (pas == ok_pass_in);
        pend = 1'b0;
      end else if (cnt == 0 && nxt && idx < BLOCKS) begin
        blk_done_out <= 1'b1;
        blk_err_out <= err_mask_in[idx];
        blk_lba_out <= 32'h00001000 + idx;
        idx++;
        nxt = 1'b0;
        pas = 0;
      end
    end
  end
endmodule

// [testbench/tb_rer_policy.sv]
`include "rer_defs.vh"
module tb_rer_policy;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic ck; logic [3:0] sk; logic [31:0] info; int nx; int np;} rer_note_t;
  logic CLK_IN = 0, RST_N_IN = 0, CE_IN = 1, PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0;
  logic [7:0] PADDR_IN = 8'h00;
  logic [31:0] PWDATA_IN = 32'h00000000, PRDATA_OUT, INFO_LBA_OUT, BLK_LBA_IN;
  logic CMD_START_IN = 0, CMD_WRITE_IN = 0, BLK_DONE_IN, BLK_ERR_IN, PASS_DONE_IN, PASS_OK_IN;
  logic [15:0] CMD_BLOCKS_IN = 16'h0003;
  logic PREADY_OUT, PSLVERR_OUT, PASS_REQ_OUT, FULL_STEPS_OUT, XFER_BLOCK_OUT, XFER_STOP_OUT;
  logic CMD_DONE_OUT, CHECK_COND_OUT, BUSY_OUT;
  logic [3:0] SENSE_KEY_OUT;
  logic [7:0] em = 8'h00;
  logic [4:0] okp = 5'h00;
  logic [2:0] slow = 3'h0;
  logic [15:0] lfsr = 16'hD9D1; // Seed 55761.
  rer_note_t notes[$];
  int miscompares = 0, cmp_count = 0, nx = 0, np = 0;

  rer_policy #(.TICK_CYCLES(4)) i_dut (.*);
  rer_media_model i_media (.clk_in(CLK_IN), .rst_n_in(RST_N_IN), .busy_in(BUSY_OUT),
    .xfer_block_in(XFER_BLOCK_OUT), .pass_req_in(PASS_REQ_OUT), .xfer_stop_in(XFER_STOP_OUT),
    .cmd_done_in(CMD_DONE_OUT), .err_mask_in(em), .ok_pass_in(okp), .slow_in(slow),
    .blk_done_out(BLK_DONE_IN), .blk_err_out(BLK_ERR_IN), .blk_lba_out(BLK_LBA_IN),
    .pass_done_out(PASS_DONE_IN), .pass_ok_out(PASS_OK_IN));

  // ----------------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------------
  always #20 CLK_IN = ~CLK_IN;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // The request is held until ready is sampled high, so a slow slave is tolerated.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    PSEL_IN <= 1'b1;
    PWRITE_IN <= w;
    PADDR_IN <= a;
    PWDATA_IN <= d;
    @(posedge CLK_IN);
    PENABLE_IN <= 1'b1;
    do begin
      @(posedge CLK_IN);
    end while (PREADY_OUT !== 1'b1);
    q = PRDATA_OUT;
    e = PSLVERR_OUT;
    PSEL_IN <= 1'b0;
    PENABLE_IN <= 1'b0;
    @(posedge CLK_IN);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m, input logic er);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
    chk("read data", ex, q & m);
    chk("slave error", er, e);
  endtask

  // Programs the mode, starts a three block command and waits for its end.
  task automatic run(input logic [9:0] c, input logic [15:0] r, input logic [15:0] t, input logic w,
                     input logic [7:0] m, input logic [4:0] k, input logic [2:0] s, input rer_note_t n);
    int i;
    wr(`RER_ADDR_CTRL, {22'h000000, c});
    wr(`RER_ADDR_RETRY, {16'h0000, r});
    wr(`RER_ADDR_TIME, {16'h0000, t});
    em <= m;
    okp <= k;
    slow <= s;
    CMD_WRITE_IN <= w;
    CMD_START_IN <= 1'b1;
    notes.push_back(n);
    @(posedge CLK_IN);
    CMD_START_IN <= 1'b0;
    for (i = 0; i < 3000 && notes.size() > 0; i++) @(posedge CLK_IN);
    chk("command ended", 0, notes.size());
    chk("full steps", ~w & ~c[8] & (r[7:0] != 8'h00), FULL_STEPS_OUT);
    @(posedge CLK_IN);
  endtask

  // Counts sent blocks and passes, then compares the oldest note at each command end.
  always @(posedge CLK_IN) begin
    rer_note_t n;
    if (CMD_START_IN === 1'b1) begin
      nx = 0;
      np = 0;
    end
    nx += (XFER_BLOCK_OUT === 1'b1);
    np += (PASS_REQ_OUT === 1'b1);
    if (CMD_DONE_OUT === 1'b1 && notes.size() > 0) begin
      n = notes.pop_front();
      chk("check status", n.ck, CHECK_COND_OUT);
      chk("sense key", n.sk, SENSE_KEY_OUT);
      if (n.ck) chk("info lba", n.info, INFO_LBA_OUT);
      chk("blocks sent", n.nx, nx);
      chk("transfer halted", n.nx < 3, XFER_STOP_OUT);
      if (n.np >= 0) chk("passes", n.np, np);
      else chk("passes below limit", 1, np < -n.np);
    end
  end

  // ----------------------------------------------------------------------------
  // Main sequence and watchdog.
  // ----------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge CLK_IN);
    RST_N_IN <= 1'b1;
    @(posedge CLK_IN);
    rchk(`RER_ADDR_CTRL, 32'h00000000, 32'hFFFFFFFF, 1'b0);
    rchk(`RER_ADDR_RETRY, 32'h00000101, 32'hFFFFFFFF, 1'b0);
    rchk(`RER_ADDR_TIME, 32'h00000000, 32'hFFFFFFFF, 1'b0);
    rchk(8'h14, 32'h00000000, 32'hFFFFFFFF, 1'b1);
    repeat (4) begin
      lfsr = lfsr_next(lfsr);
      wr(`RER_ADDR_TIME, {16'h0000, lfsr});
      rchk(`RER_ADDR_TIME, {16'h0000, lfsr}, 32'h0000FFFF, 1'b0);
    end
    wr(`RER_ADDR_CTRL, 32'h00000002);
    rchk(`RER_ADDR_STATUS, 32'h00000040, 32'h00000040, 1'b0);
    run(10'h000, 16'h0101, 16'h0000, 1'b0, 8'h02, 5'd1, 3'd0, '{1'b0, 4'h0, 0, 3, 1});
    run(10'h004, 16'h0101, 16'h0000, 1'b0, 8'h03, 5'd1, 3'd2, '{1'b1, 4'h1, 32'h1001, 3, 2});
    run(10'h004, 16'h0101, 16'h0000, 1'b0, 8'h00, 5'd1, 3'd0, '{1'b0, 4'h0, 0, 3, 0});
    run(10'h006, 16'h0101, 16'h0000, 1'b0, 8'h02, 5'd1, 3'd0, '{1'b1, 4'h1, 32'h1001, 2, 1});
    run(10'h100, 16'h0102, 16'h0000, 1'b0, 8'h02, 5'd0, 3'd0, '{1'b1, 4'h3, 32'h1001, 1, 2});
    run(10'h120, 16'h0102, 16'h0000, 1'b0, 8'h02, 5'd0, 3'd1, '{1'b1, 4'h3, 32'h1001, 2, 2});
    run(10'h000, 16'h0100, 16'h0000, 1'b0, 8'h02, 5'd0, 3'd0, '{1'b1, 4'h3, 32'h1001, 1, 0});
    run(10'h000, 16'h0105, 16'h0000, 1'b0, 8'h02, 5'd0, 3'd3, '{1'b1, 4'h3, 32'h1001, 1, 16});
    run(10'h000, 16'h0300, 16'h0000, 1'b1, 8'h02, 5'd0, 3'd0, '{1'b1, 4'h3, 32'h1001, 1, 3});
    run(10'h000, 16'h0101, 16'd60, 1'b0, 8'h02, 5'd0, 3'd3, '{1'b1, 4'h3, 32'h1001, 1, -16});
    run(10'h200, 16'h1000, 16'd60, 1'b1, 8'h02, 5'd0, 3'd3, '{1'b1, 4'h3, 32'h1001, 1, 16});
    run(10'h010, 16'h0101, 16'h0000, 1'b0, 8'h07, 5'd0, 3'd0, '{1'b0, 4'h0, 0, 3, 0});
    end_of_test();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #800000;
    miscompares++;
    $display("CHECK FAILED watchdog expected end seen timeout");
    end_of_test();
  end
endmodule
